/* src/dof_pkg.sv */
// Package: register map, field positions and defaults of the output formatter
package dof_pkg;
    // ************
    // Register map
    // ************
    localparam logic [7:0] reg_output_format_ctrl = 8'h18;
    localparam logic [7:0] reg_hsync_out_width = 8'h19;
    localparam logic [7:0] reg_output_pin_disable = 8'h1a;
    localparam logic [7:0] reg_power_down_ctrl = 8'h1b;
    localparam logic [7:0] reg_pll_tuning_value = 8'h1c;
    localparam int addr_width = 10;
    // ************
    // Reset values
    // ************
    localparam logic [7:0] rst_output_format_ctrl = 8'h00;
    localparam logic [7:0] rst_hsync_out_width = 8'h10;
    localparam logic [7:0] rst_output_pin_disable = 8'h00;
    localparam logic [7:0] rst_power_down_ctrl = 8'h00;
    localparam logic [7:0] rst_pll_tuning_value = 8'h49;
    localparam logic [7:0] power_down_mask = 8'h0f;
    // ************
    // Field positions
    // ************
    localparam int fmt_wide = 0;
    localparam int fmt_interleave = 1;
    localparam int fmt_swap = 2;
    localparam int fmt_uv_order = 3;
    localparam int fmt_422 = 4;
    localparam int fmt_clk_pol = 5;
    localparam int fmt_vs_pol = 6;
    localparam int fmt_hs_pol = 7;
    localparam int dis_red_p = 0;
    localparam int dis_red_s = 1;
    localparam int dis_green_p = 2;
    localparam int dis_green_s = 3;
    localparam int dis_blue_p = 4;
    localparam int dis_blue_s = 5;
    localparam int dis_clk_a = 6;
    localparam int dis_clk_b = 7;
    localparam int pd_red = 0;
    localparam int pd_green = 1;
    localparam int pd_blue = 2;
    localparam int pd_pll = 3;
    localparam int fifo_depth = 8;
    localparam int pixel_width = 24;
endpackage

/* src/dof_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dof_fifo #(
    parameter int width = 24,
    parameter int depth = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    typedef struct packed {
        logic [aw-1:0] wr_ptr;
        logic [aw-1:0] rd_ptr;
        logic [aw:0] count;
    } dof_fifo_state_type;
    dof_fifo_state_type state;
    dof_fifo_state_type next_state;
    logic [width-1:0] mem [depth];
    logic push;
    logic pop;
    assign in_ready = state.count != (aw+1)'(depth);
    assign out_valid = state.count != '0;
    assign out_data = mem[state.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.wr_ptr = (state.wr_ptr == aw'(depth - 1)) ? '0 : state.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_state.rd_ptr = (state.rd_ptr == aw'(depth - 1)) ? '0 : state.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_state.count = state.count + 1'b1;
        end else if (pop && !push) begin
            next_state.count = state.count - 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    // Storage has no reset; contents are qualified by count
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[state.wr_ptr] <= in_data;
        end
    end
endmodule

/* src/dof_formatter.sv */
// Output formatter: pixel bus, sync outputs, pin enables, power controls, registers
// How it works
// RULE1: Narrow bus drives secondary bytes low
// RULE2: Interleave updates secondary on opposite edge
// RULE3: Swap puts first pixel on secondary
// RULE4: UV order selects even or odd V
// RULE5: 4:2:2 decimates chroma, blue low
// RULE6: Clock polarity picks data change edge
// RULE7: Sync polarity bits invert sync outputs
// RULE8: Line sync width equals programmed count
// RULE9: Software keeps sync width at minimum
// RULE10: Six bits float individual output bytes
// RULE11: Byte disables override all other settings
// RULE12: Clock disable floats pixel clock output
// RULE13: Channel power-down bits stop converters
// RULE14: PLL power-down bit stops PLL
// RULE15: Software keeps PLL tuning recommended value
// RULE16: Registers take defaults at reset
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module dof_formatter #(
    parameter int fifo_words = dof_pkg::fifo_depth
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [dof_pkg::addr_width-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pixel_clock_in,
    input wire logic line_sync_in,
    input wire logic frame_sync_in,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [7:0] pix_red,
    input wire logic [7:0] pix_green,
    input wire logic [7:0] pix_blue,
    output logic [7:0] red_primary_byte,
    output logic [7:0] red_secondary_byte,
    output logic [7:0] green_primary_byte,
    output logic [7:0] green_secondary_byte,
    output logic [7:0] blue_primary_byte,
    output logic [7:0] blue_secondary_byte,
    output logic [5:0] byte_oe,
    output logic pixel_out_clock,
    output logic pixel_out_clock_oe,
    output logic line_sync_out,
    output logic frame_sync_out,
    output logic red_adc_power_down,
    output logic green_adc_power_down,
    output logic blue_adc_power_down,
    output logic pll_power_down,
    output logic [7:0] pll_tuning
);
    import dof_pkg::*;

    // ************
    // State
    // ************
    typedef struct packed {
        logic [2:0] clk_sync;
        logic [1:0] hs_sync;
        logic [1:0] vs_sync;
        logic hs_prev;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] fmt;
        logic [7:0] hs_width;
        logic [7:0] pin_dis;
        logic [7:0] pwr;
        logic [7:0] tune;
        logic [7:0] hs_count;
        logic hs_active;
        logic vs_active;
        logic lane_sec;
        logic pair_odd;
        logic [7:0] held_v;
        logic [47:0] bus_p;
        logic [23:0] pend_s;
        logic [23:0] bus_s;
        logic clk_out;
    } dof_state_type;
    dof_state_type state;
    dof_state_type next_state;

    logic [23:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic launch_edge;
    logic other_edge;
    logic hs_rise;
    logic lane_now;
    logic odd_now;
    logic wide;
    logic [23:0] pixel;
    logic [7:0] reg_value;
    logic [31:0] wmask;

    // Source pixels are buffered so a stalled output does not lose samples
    dof_fifo #(
        .width(pixel_width),
        .depth(fifo_words)
    ) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data({pix_red, pix_green, pix_blue}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    function automatic logic [7:0] reg_read(input logic [7:0] idx, input dof_state_type s);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            reg_output_format_ctrl: v = s.fmt;
            reg_hsync_out_width: v = s.hs_width;
            reg_output_pin_disable: v = s.pin_dis;
            reg_power_down_ctrl: v = s.pwr;
            reg_pll_tuning_value: v = s.tune;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ************
    // Edge detection on the sampled pixel clock
    // ************
    // RULE6: choose launch edge
    assign launch_edge = state.fmt[fmt_clk_pol] ? (state.clk_sync[2:1] == 2'b01)
                                                : (state.clk_sync[2:1] == 2'b10);
    assign other_edge = state.fmt[fmt_clk_pol] ? (state.clk_sync[2:1] == 2'b10)
                                               : (state.clk_sync[2:1] == 2'b01);
    assign hs_rise = state.hs_sync[1] && !state.hs_prev;
    assign wide = state.fmt[fmt_wide];
    assign fifo_pop = launch_edge && fifo_valid;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign reg_value = reg_read(avs_address[9:2], state);

    always_comb begin
        next_state = state;
        pixel = fifo_data;
        // Line start wins over the running lane and pair phase
        lane_now = hs_rise ? state.fmt[fmt_swap] : state.lane_sec;
        odd_now = hs_rise ? 1'b0 : state.pair_odd;
        next_state.clk_sync = {state.clk_sync[1:0], pixel_clock_in};
        next_state.hs_sync = {state.hs_sync[0], line_sync_in};
        next_state.vs_sync = {state.vs_sync[0], frame_sync_in};

        // ************
        // Avalon slave: one wait state, answers unmapped with zero
        // ************
        next_state.ack = (avs_read || avs_write) && !state.ack;
        if ((avs_read || avs_write) && !state.ack) begin
            next_state.rdata = {24'h0, reg_value};
        end
        if (avs_write && state.ack && wmask[0]) begin
            unique case (avs_address[9:2])
                reg_output_format_ctrl: next_state.fmt = avs_writedata[7:0];
                reg_hsync_out_width: next_state.hs_width = avs_writedata[7:0];
                reg_output_pin_disable: next_state.pin_dis = avs_writedata[7:0];
                // RULE13: converter power bits
                // RULE14: PLL power bit
                reg_power_down_ctrl: next_state.pwr = avs_writedata[7:0] & power_down_mask;
                reg_pll_tuning_value: next_state.tune = avs_writedata[7:0];
                default: next_state.tune = state.tune;
            endcase
        end

        if (launch_edge) begin
            next_state.hs_prev = state.hs_sync[1];
            next_state.vs_active = state.vs_sync[1];
            next_state.clk_out = state.fmt[fmt_clk_pol];
            // RULE8: width counter in pixels
            if (hs_rise) begin
                next_state.hs_active = state.hs_width != 8'h00;
                next_state.hs_count = state.hs_width;
            end else if (state.hs_count > 8'h01) begin
                next_state.hs_count = state.hs_count - 8'h01;
            end else begin
                next_state.hs_count = 8'h00;
                next_state.hs_active = 1'b0;
            end
            // RULE3: lane restarts at line start
            next_state.lane_sec = lane_now;
            next_state.pair_odd = odd_now;
            if (fifo_valid) begin
                // RULE5: chroma decimation, blue low
                if (state.fmt[fmt_422]) begin
                    next_state.pair_odd = !odd_now;
                    if (!odd_now) begin
                        // Even sample shows U, keeps its V for the pair
                        next_state.held_v = fifo_data[23:16];
                        pixel = {fifo_data[7:0], fifo_data[15:8], 8'h00};
                    end else begin
                        // RULE4: even or odd V
                        pixel = {state.fmt[fmt_uv_order] ? fifo_data[23:16] : state.held_v, fifo_data[15:8], 8'h00};
                    end
                end
                if (wide) begin
                    next_state.lane_sec = !lane_now;
                    if (lane_now) begin
                        next_state.pend_s = pixel;
                    end else begin
                        next_state.bus_p[47:24] = pixel;
                    end
                end else begin
                    // RULE1: secondary low on narrow bus
                    next_state.bus_p = {pixel, 24'h0};
                    next_state.pend_s = 24'h0;
                end
            end
            // RULE2: same-edge secondary update
            if (!wide || !state.fmt[fmt_interleave]) begin
                next_state.bus_s = wide ? next_state.pend_s : 24'h0;
            end
        end
        if (other_edge) begin
            next_state.clk_out = !state.fmt[fmt_clk_pol];
            // RULE2: opposite-edge secondary update
            if (wide && state.fmt[fmt_interleave]) begin
                next_state.bus_s = state.pend_s;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
            // RULE16: register defaults
            state.fmt <= rst_output_format_ctrl;
            state.hs_width <= rst_hsync_out_width;
            state.pin_dis <= rst_output_pin_disable;
            state.pwr <= rst_power_down_ctrl;
            state.tune <= rst_pll_tuning_value;
        end else begin
            state <= next_state;
        end
    end

    // ************
    // Outputs
    // ************
    assign avs_waitrequest = (avs_read || avs_write) && !state.ack;
    assign avs_readdata = state.rdata;
    assign red_primary_byte = state.bus_p[47:40];
    assign green_primary_byte = state.bus_p[39:32];
    assign blue_primary_byte = state.bus_p[31:24];
    assign red_secondary_byte = state.bus_s[23:16];
    assign green_secondary_byte = state.bus_s[15:8];
    assign blue_secondary_byte = state.bus_s[7:0];
    // RULE10: per-byte floats
    // RULE11: disables override everything
    assign byte_oe = ~{state.pin_dis[dis_blue_s], state.pin_dis[dis_blue_p], state.pin_dis[dis_green_s],
                       state.pin_dis[dis_green_p], state.pin_dis[dis_red_s], state.pin_dis[dis_red_p]};
    assign pixel_out_clock = state.clk_out;
    // RULE12: clock float
    assign pixel_out_clock_oe = !(state.pin_dis[dis_clk_a] || state.pin_dis[dis_clk_b]);
    // RULE7: sync polarity
    assign line_sync_out = state.hs_active ^ state.fmt[fmt_hs_pol];
    assign frame_sync_out = state.vs_active ^ state.fmt[fmt_vs_pol];
    assign red_adc_power_down = state.pwr[pd_red];
    assign green_adc_power_down = state.pwr[pd_green];
    assign blue_adc_power_down = state.pwr[pd_blue];
    assign pll_power_down = state.pwr[pd_pll];
    assign pll_tuning = state.tune;
endmodule

/* verification/dof_props.sv */
// Checker: port assertions of the output formatter
`timescale 1ns/1ps
module dof_props
import dof_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [dof_pkg::addr_width-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [7:0] red_primary_byte,
    input wire logic [7:0] red_secondary_byte,
    input wire logic [7:0] blue_primary_byte,
    input wire logic [7:0] blue_secondary_byte,
    input wire logic [5:0] byte_oe,
    input wire logic pixel_out_clock,
    input wire logic pixel_out_clock_oe,
    input wire logic line_sync_out,
    input wire logic frame_sync_in,
    input wire logic frame_sync_out,
    input wire logic red_adc_power_down,
    input wire logic green_adc_power_down,
    input wire logic blue_adc_power_down,
    input wire logic pll_power_down,
    input wire logic [7:0] pll_tuning
);
    // ************
    // Register mirror
    // ************
    logic [31:0] regs;
    logic [4:0] quiet;
    logic [7:0] fmt;
    logic [7:0] idx;
    logic ok;
    logic wr;
    assign fmt = regs[31:24];
    assign idx = avs_address[9:2];
    // Outputs are judged only once writes have settled
    assign ok = quiet == 5'h1f;
    assign wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            regs <= {rst_output_format_ctrl, rst_output_pin_disable, rst_power_down_ctrl, rst_pll_tuning_value};
            quiet <= 5'h00;
        end else begin
            quiet <= wr ? 5'h00 : quiet + {4'h0, !ok};
            if (wr && idx == reg_output_format_ctrl) regs[31:24] <= avs_writedata[7:0];
            if (wr && idx == reg_output_pin_disable) regs[23:16] <= avs_writedata[7:0];
            if (wr && idx == reg_power_down_ctrl) regs[15:8] <= avs_writedata[7:0];
            if (wr && idx == reg_pll_tuning_value) regs[7:0] <= avs_writedata[7:0];
        end
    end
    // ************
    // Assertions
    // ************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_narrow_low: assert property (ok && !fmt[0] |-> (red_secondary_byte | blue_secondary_byte) == 8'h00)
        else $error("secondary byte driven in narrow mode");
    a_sec_edge: assert property (ok && fmt[1:0] == 2'b11 && $changed(red_secondary_byte)
        |-> (fmt[5] ? $fell(pixel_out_clock) : $rose(pixel_out_clock))) else $error("secondary edge wrong");
    a_blue_low: assert property (ok && fmt[4] |-> (blue_primary_byte | blue_secondary_byte) == 8'h00)
        else $error("blue driven in 4:2:2");
    a_prim_edge: assert property (ok && $changed(red_primary_byte)
        |-> (fmt[5] ? $rose(pixel_out_clock) : $fell(pixel_out_clock))) else $error("primary edge wrong");
    a_frame_pol: assert property (ok && !frame_sync_in |-> frame_sync_out == fmt[6])
        else $error("frame sync idle level wrong");
    a_byte_float: assert property (ok |-> byte_oe == ~regs[21:16])
        else $error("byte enable wrong");
    a_clock_float: assert property (ok |-> pixel_out_clock_oe == (regs[23:22] == 2'b00))
        else $error("clock enable wrong");
    a_power_pins: assert property (ok |->
        {pll_power_down, blue_adc_power_down, green_adc_power_down, red_adc_power_down} == regs[11:8])
        else $error("power pins wrong");
    a_tune_out: assert property (ok |-> pll_tuning == regs[7:0])
        else $error("tuning output wrong");
    c_interleave: cover property (ok && fmt[1:0] == 2'b11 && $changed(red_secondary_byte));
    c_line_sync: cover property ($fell(line_sync_out));
    c_decimate: cover property (ok && fmt[4] && $changed(red_primary_byte));
endmodule
bind dof_formatter dof_props u_dof_props (.mclk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_waitrequest, .red_primary_byte, .red_secondary_byte, .blue_primary_byte,
    .blue_secondary_byte, .byte_oe, .pixel_out_clock, .pixel_out_clock_oe, .line_sync_out, .frame_sync_in,
    .frame_sync_out, .red_adc_power_down, .green_adc_power_down, .blue_adc_power_down, .pll_power_down, .pll_tuning);

/* verification/dof_sink.sv */
// Partner model: downstream processor measuring line sync pulses
`timescale 1ns/1ps
module dof_sink (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic line_sync_out,
    input wire logic active_low,
    output logic [7:0] pulse_len
);
    logic [7:0] run;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            run <= 8'h00;
            pulse_len <= 8'h00;
        end else if (line_sync_out ^ active_low) begin
            run <= run + 8'h01;
        end else begin
            if (run != 8'h00) pulse_len <= run;
            run <= 8'h00;
        end
    end
endmodule

/* verification/dof_formatter_bench.sv */
// Testbench: output formatter registers, stream and sync
`timescale 1ns/1ps
module dof_formatter_bench;
import dof_pkg::*;
logic mclk = 0, arst_n = 0, pixel_clock_in = 0, lk_run = 0, hs_low = 0;
logic avs_read = 0, avs_write = 0, line_sync_in = 0, frame_sync_in = 0, pix_valid = 0;
logic [9:0] avs_address = 10'h000;
logic [31:0] avs_writedata = 32'h0, avs_readdata;
logic [3:0] avs_byteenable = 4'hf;
logic [7:0] pix_red = 8'h00, pix_green = 8'h00, pix_blue = 8'h00, pll_tuning, pulse_len;
logic [7:0] red_primary_byte, red_secondary_byte, green_primary_byte, green_secondary_byte;
logic [7:0] blue_primary_byte, blue_secondary_byte;
logic [5:0] byte_oe;
logic avs_waitrequest, pix_ready, pixel_out_clock, pixel_out_clock_oe, line_sync_out, frame_sync_out;
logic red_adc_power_down, green_adc_power_down, blue_adc_power_down, pll_power_down;
int errors = 0, n_compared = 0;
always #20 mclk = ~mclk;
// Link clock stands still between bursts
always #160 if (lk_run) pixel_clock_in = ~pixel_clock_in;
dof_formatter u_dof_formatter (.mclk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pixel_clock_in, .line_sync_in, .frame_sync_in,
    .pix_valid, .pix_ready, .pix_red, .pix_green, .pix_blue, .red_primary_byte, .red_secondary_byte,
    .green_primary_byte, .green_secondary_byte, .blue_primary_byte, .blue_secondary_byte, .byte_oe,
    .pixel_out_clock, .pixel_out_clock_oe, .line_sync_out, .frame_sync_out, .red_adc_power_down,
    .green_adc_power_down, .blue_adc_power_down, .pll_power_down, .pll_tuning);
dof_sink u_dof_sink (.mclk, .arst_n, .line_sync_out, .active_low(hs_low), .pulse_len);
// ************
// Tasks
// ************
task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
        errors++;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic bus(input logic w, input logic [7:0] r, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    avs_address <= {r, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
endtask
task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, r, d, q);
endtask
task automatic chk(input logic [7:0] r, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, r, 8'h00, q);
    cmp(q, e);
endtask
task automatic t_defaults;
    chk(reg_output_format_ctrl, 8'h00);
    chk(reg_hsync_out_width, 8'h10);
    chk(reg_output_pin_disable, 8'h00);
    chk(reg_power_down_ctrl, 8'h00);
    chk(reg_pll_tuning_value, 8'h49);
    chk(8'h30, 8'h00);
endtask
task automatic t_regs;
    wr(reg_power_down_ctrl, 8'hff);
    chk(reg_power_down_ctrl, 8'h0f);
    cmp({4'h0, pll_power_down, blue_adc_power_down, green_adc_power_down, red_adc_power_down}, 8'h0f);
    wr(reg_pll_tuning_value, 8'h4c);
    chk(reg_pll_tuning_value, 8'h4c);
    cmp(pll_tuning, 8'h4c);
    wr(reg_power_down_ctrl, 8'h00);
    chk(reg_power_down_ctrl, 8'h00);
endtask
// Fill the buffer with link stopped, then drain it
task automatic t_stream(input logic [7:0] f, input logic [7:0] v, input logic [7:0] rp,
    input logic [7:0] rs, input logic [7:0] bp);
    int n;
    n = 0;
    wr(reg_output_format_ctrl, f);
    @(posedge mclk);
    pix_red <= v;
    pix_green <= ~v;
    pix_blue <= v + 8'h11;
    pix_valid <= 1'b1;
    while (n < 20) begin
        @(negedge mclk);
        if (pix_ready !== 1'b1) break;
        n++;
        @(posedge mclk);
        // Red steps per pixel so lane and chroma order show
        pix_red <= v + 8'(n);
    end
    @(posedge mclk);
    pix_valid <= 1'b0;
    cmp(8'(n), 8'(fifo_depth));
    // Wide runs open a line so the first pixel takes the swap lane
    if (f[0]) line_sync_in <= 1'b1;
    lk_run = 1;
    repeat (56) @(posedge mclk);
    line_sync_in <= 1'b0;
    repeat (56) @(posedge mclk);
    lk_run = 0;
    @(negedge mclk);
    cmp({7'h00, pix_ready}, 8'h01);
    cmp(green_primary_byte, ~v);
    cmp(red_secondary_byte, rs);
    cmp(blue_primary_byte, bp);
    cmp(red_primary_byte, rp);
endtask
task automatic t_hsync;
    wr(reg_hsync_out_width, 8'h03);
    wr(reg_output_format_ctrl, 8'hc0);
    hs_low = 1;
    repeat (2) @(negedge mclk);
    cmp({7'h00, line_sync_out}, 8'h01);
    cmp({7'h00, frame_sync_out}, 8'h01);
    lk_run = 1;
    repeat (24) @(posedge mclk);
    line_sync_in <= 1'b1;
    repeat (80) @(posedge mclk);
    line_sync_in <= 1'b0;
    repeat (40) @(posedge mclk);
    lk_run = 0;
    cmp(pulse_len, 8'h18);
endtask
task automatic t_disable;
    logic [7:0] v [5] = '{8'hff, 8'h15, 8'h40, 8'h80, 8'h00};
    foreach (v[i]) begin
        wr(reg_output_pin_disable, v[i]);
        repeat (2) @(negedge mclk);
        cmp({2'b00, byte_oe}, {2'b00, ~v[i][5:0]});
        cmp({7'h00, pixel_out_clock_oe}, {7'h00, v[i][7:6] == 2'b00});
    end
endtask
task automatic test_done;
    if (errors == 0 && n_compared > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
// ************
// Sequence
// ************
initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_defaults();
    t_regs();
    t_stream(8'h10, 8'h81, 8'h87, 8'h00, 8'h00);
    t_stream(8'h18, 8'h42, 8'h49, 8'h00, 8'h00);
    t_stream(8'h00, 8'h5a, 8'h61, 8'h00, 8'h6b);
    t_hsync();
    t_stream(8'h01, 8'hc3, 8'hc9, 8'hca, 8'hd4);
    t_stream(8'h07, 8'h96, 8'h9d, 8'h9c, 8'ha7);
    t_stream(8'h23, 8'h3c, 8'h42, 8'h43, 8'h4d);
    t_disable();
    test_done();
end
initial begin
    #2000000;
    errors++;
    $display("ERROR %0t: timeout", $time);
    test_done();
end
endmodule
